// File: cpt_pkg.sv
// constants shared by the center-aligned pwm timer: register map, fields, codes
// assumes a 32-bit classic wishbone master and byte addressing
`default_nettype none
package cpt_pkg;

    // ==============================================================
    // register byte offsets
    localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_MAIN_COUNTER = 8'h04;
    localparam logic [7:0] OFS_MODULO_VALUE = 8'h08;
    localparam logic [7:0] OFS_CHANNEL_VALUE = 8'h0c;
    localparam logic [7:0] OFS_CHANNEL_CONTROL = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    // ==============================================================
    // timer_status_control fields
    localparam int SC_OVF_BIT = 7;
    localparam int SC_OVF_IE_BIT = 6;
    localparam int SC_CPWM_BIT = 5;
    localparam int SC_CLKS_LSB = 3;
    localparam int SC_PS_LSB = 0;

    // channel control and interrupt fields
    localparam int CC_POL_BIT = 0;
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_MATCH_BIT = 1;

    // ==============================================================
    // clock source codes
    localparam logic [1:0] CLKS_OFF = 2'h0;
    localparam logic [1:0] CLKS_BUS = 2'h1;
    localparam logic [1:0] CLKS_FIXED = 2'h2;
    localparam logic [1:0] CLKS_EXT = 2'h3;

    // ==============================================================
    // reset values
    localparam logic [1:0] CLKS_RESET = 2'h0;
    localparam logic [2:0] PS_RESET = 3'h0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] MODULO_RESET = 16'h0000;
    localparam logic [15:0] CHANNEL_RESET = 16'h0000;

    // counter landmarks
    localparam logic [15:0] COUNT_FREE_PRELOAD = 16'hfffe;
    localparam logic [15:0] COUNT_TOP = 16'hffff;
    localparam logic [15:0] COUNT_ONE = 16'h0001;

    // prescaler divider width, enough for the largest factor of 128
    localparam int PS_DIV_W = 7;

endpackage

`default_nettype wire

// File: cpt_timer.sv
// center-aligned pwm timer: 16-bit main counter, prescaler, one pwm channel,
// wishbone classic slave registers and a level interrupt
// assumes ref_clk is the bus clock; clock pins are asynchronous to it
//
// Summary of operation
// R1: two-bit clock source select, three sources or off
// R2: clock source select resets to zero
// R3: select always accessible; off keeps counter, registers
// R4: free-running buffered update at 0xfffe to 0xffff
// R5: center select makes counter count up and down
// R6: center pulse width is twice channel value
// R7: up to modulo, down to zero, period twice
// R8: software keeps modulo within 0x0001 to 0x7fff
// R9: up match drives low, down match high
// R10: zero or negative channel value gives 0% duty
// R11: channel value above modulo gives 100% duty
// R12: software never uses zero modulo when centered
// R13: non-centered zero modulo runs full 16-bit range
// R14: reversal only on modulo match away from zero
// R15: three-bit prescale, effective on next cycle
// R16: overflow flag sets on wrap; read-then-write-zero clears
// R17: external clock synchronised before the prescaler
// R18: one step per prescaled tick, hold when off
//
// Design decisions made here: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`default_nettype none

module cpt_timer
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbWrData,
    output logic [31:0] wbRdData,
    output logic wbAck,
    input wire logic extClkPin,
    input wire logic fixedClkPin,
    output logic pwmOut,
    output logic irq
);

    // ==============================================================
    // state
    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] sync3;
        logic [1:0] stable;
        logic [cpt_pkg::PS_DIV_W-1:0] div;
        logic [15:0] cnt;
        logic down;
        logic ovf;
        logic ovfArmed;
        logic ovfIe;
        logic cpwm;
        logic [1:0] clks;
        logic [2:0] ps;
        logic [15:0] modulo;
        logic [15:0] moduloBuf;
        logic [15:0] chv;
        logic [15:0] chvBuf;
        logic pend;
        logic pol;
        logic active;
        logic pwm;
        logic [1:0] irqStat;
        logic [1:0] irqMask;
        logic ack;
        logic [31:0] dat;
    } cpt_state_s;

    cpt_state_s r;
    cpt_state_s next_r;

    // ==============================================================
    // byte-lane merge for the 16-bit registers
    function automatic logic [15:0] cpt_merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [15:0] m;
        m = old;
        if (s[0])
        begin
            m[7:0] = d[7:0];
        end
        if (s[1])
        begin
            m[15:8] = d[15:8];
        end
        return m;
    endfunction

    logic access;
    logic [1:0] rise;
    logic srcTick;
    logic tick;
    logic [cpt_pkg::PS_DIV_W-1:0] psMask;
    logic [15:0] nextCnt;
    logic nextDown;
    logic ovfEvt;
    logic loadEvt;
    logic matchEvt;
    logic stepDown;

    // ==============================================================
    // next state
    always_comb
    begin
        next_r = r;
        next_r.ack = 1'b0;
        access = wbCyc & wbStb & ~r.ack;

        // three-stage synchroniser; a level counts once stages two and three agree
        next_r.sync1 = {extClkPin, fixedClkPin}; // R17
        next_r.sync2 = r.sync1; // R17
        next_r.sync3 = r.sync2; // R17
        next_r.stable = (r.stable & (r.sync2 ^ r.sync3)) | (r.sync3 & ~(r.sync2 ^ r.sync3)); // R17
        rise = next_r.stable & ~r.stable;

        // source selection; off gives no ticks, so the counter and prescaler simply hold
        unique case (r.clks) // R1
            cpt_pkg::CLKS_OFF: srcTick = 1'b0; // R3
            cpt_pkg::CLKS_BUS: srcTick = 1'b1;
            cpt_pkg::CLKS_FIXED: srcTick = rise[0];
            cpt_pkg::CLKS_EXT: srcTick = rise[1]; // R17
        endcase

        // prescaler reads the live field, so a new factor acts next cycle
        psMask = cpt_pkg::PS_DIV_W'(7'h7f >> (3'h7 - r.ps)); // R15
        tick = srcTick & ((r.div & psMask) == psMask); // R15
        if (srcTick)
        begin
            next_r.div = r.div + 1'b1;
        end

        // ==========================================================
        // main counter
        nextCnt = r.cnt;
        nextDown = r.down;
        ovfEvt = 1'b0;
        loadEvt = 1'b0;
        if (tick) // R18
        begin
            if (r.cpwm) // R5
            begin
                if (!r.down)
                begin
                    if (r.cnt == r.modulo && r.cnt != 16'h0000) // R14
                    begin
                        nextDown = 1'b1; // R7
                        nextCnt = r.cnt - 1'b1; // R7
                        loadEvt = 1'b1;
                        ovfEvt = (r.cnt == cpt_pkg::COUNT_ONE); // R16
                    end
                    else
                    begin
                        nextCnt = r.cnt + 1'b1; // R18
                    end
                end
                else if (r.cnt <= cpt_pkg::COUNT_ONE)
                begin
                    // bottom of the down slope; a modulo of one reverses at zero, so no zero repeats
                    nextCnt = (r.cnt == cpt_pkg::COUNT_ONE) ? cpt_pkg::COUNT_RESET : cpt_pkg::COUNT_ONE; // R7
                    nextDown = 1'b0; // R7
                    ovfEvt = (r.cnt == cpt_pkg::COUNT_ONE); // R16
                end
                else
                begin
                    nextCnt = r.cnt - 1'b1; // R18
                end
            end
            else
            begin
                nextDown = 1'b0;
                if ((r.modulo != 16'h0000 && r.cnt == r.modulo) || r.cnt == cpt_pkg::COUNT_TOP) // R13
                begin
                    nextCnt = cpt_pkg::COUNT_RESET; // R16
                    ovfEvt = 1'b1; // R16
                    loadEvt = (r.modulo != 16'h0000);
                end
                else
                begin
                    nextCnt = r.cnt + 1'b1; // R13
                    loadEvt = (r.modulo == 16'h0000) && (r.cnt == cpt_pkg::COUNT_FREE_PRELOAD); // R4
                end
            end
        end
        next_r.cnt = nextCnt;
        next_r.down = nextDown;

        // ==========================================================
        // channel compare: only a real step into the value counts as a match
        stepDown = (nextCnt < r.cnt);
        matchEvt = r.cpwm && tick && (nextCnt == r.chv) && (nextCnt != r.cnt);
        if (matchEvt)
        begin
            next_r.active = stepDown; // R9
        end
        if (!r.cpwm)
        begin
            next_r.active = 1'b0;
        end
        else if (r.chv == 16'h0000 || r.chv[15]) // R10
        begin
            next_r.active = 1'b0; // R10
        end
        else if (r.modulo != 16'h0000 && r.chv >= r.modulo) // R11
        begin
            // the up match never happens, or coincides with the reversal
            next_r.active = 1'b1; // R11
        end
        next_r.pwm = next_r.active ^ r.pol; // R6

        // buffered values move in at the period landmarks or on a write to the main counter
        if (loadEvt && r.pend) // R4
        begin
            next_r.modulo = r.moduloBuf; // R4
            next_r.chv = r.chvBuf; // R4
            next_r.pend = 1'b0;
        end

        // ==========================================================
        // overflow flag and interrupt status; a new event restarts clearing
        if (ovfEvt)
        begin
            next_r.ovf = 1'b1; // R16
            next_r.ovfArmed = 1'b0; // R16
        end
        next_r.irqStat = r.irqStat | {matchEvt, ovfEvt};

        // ==========================================================
        // wishbone slave
        if (access)
        begin
            next_r.ack = 1'b1;
            next_r.dat = 32'h0000_0000;
            if (!wbWe)
            begin
                unique case (wbAdr)
                    cpt_pkg::OFS_STATUS_CONTROL:
                    begin
                        next_r.dat[cpt_pkg::SC_OVF_BIT] = r.ovf;
                        next_r.dat[cpt_pkg::SC_OVF_IE_BIT] = r.ovfIe;
                        next_r.dat[cpt_pkg::SC_CPWM_BIT] = r.cpwm;
                        next_r.dat[cpt_pkg::SC_CLKS_LSB+:2] = r.clks; // R3
                        next_r.dat[cpt_pkg::SC_PS_LSB+:3] = r.ps;
                        if (r.ovf && !ovfEvt)
                        begin
                            next_r.ovfArmed = 1'b1; // R16
                        end
                    end
                    cpt_pkg::OFS_MAIN_COUNTER: next_r.dat[15:0] = r.cnt;
                    cpt_pkg::OFS_MODULO_VALUE: next_r.dat[15:0] = r.modulo;
                    cpt_pkg::OFS_CHANNEL_VALUE: next_r.dat[15:0] = r.chv;
                    cpt_pkg::OFS_CHANNEL_CONTROL: next_r.dat[cpt_pkg::CC_POL_BIT] = r.pol;
                    cpt_pkg::OFS_IRQ_STATUS:
                    begin
                        next_r.dat[1:0] = r.irqStat;
                        // read clears, but an event in this cycle survives
                        next_r.irqStat = {matchEvt, ovfEvt};
                    end
                    cpt_pkg::OFS_IRQ_MASK: next_r.dat[1:0] = r.irqMask;
                    default: next_r.dat = 32'h0000_0000;
                endcase
            end
            else
            begin
                unique case (wbAdr)
                    cpt_pkg::OFS_STATUS_CONTROL:
                    begin
                        if (wbSel[0])
                        begin
                            next_r.ovfIe = wbWrData[cpt_pkg::SC_OVF_IE_BIT];
                            next_r.cpwm = wbWrData[cpt_pkg::SC_CPWM_BIT]; // R5
                            next_r.clks = wbWrData[cpt_pkg::SC_CLKS_LSB+:2]; // R3
                            next_r.ps = wbWrData[cpt_pkg::SC_PS_LSB+:3]; // R15
                            // writing one has no effect; zero clears only after the read
                            if (!wbWrData[cpt_pkg::SC_OVF_BIT] && r.ovfArmed && !ovfEvt)
                            begin
                                next_r.ovf = 1'b0; // R16
                                next_r.ovfArmed = 1'b0; // R16
                            end
                        end
                    end
                    cpt_pkg::OFS_MAIN_COUNTER:
                    begin
                        // manual reset: any write restarts the period and loads buffers
                        next_r.cnt = cpt_pkg::COUNT_RESET;
                        next_r.div = '0;
                        next_r.down = 1'b0;
                        next_r.modulo = r.pend ? r.moduloBuf : r.modulo;
                        next_r.chv = r.pend ? r.chvBuf : r.chv;
                        next_r.pend = 1'b0;
                    end
                    cpt_pkg::OFS_MODULO_VALUE:
                    begin
                        next_r.moduloBuf = cpt_merge(r.moduloBuf, wbWrData, wbSel);
                        next_r.pend = 1'b1;
                    end
                    cpt_pkg::OFS_CHANNEL_VALUE:
                    begin
                        next_r.chvBuf = cpt_merge(r.chvBuf, wbWrData, wbSel);
                        next_r.pend = 1'b1;
                    end
                    cpt_pkg::OFS_CHANNEL_CONTROL:
                    begin
                        if (wbSel[0])
                        begin
                            next_r.pol = wbWrData[cpt_pkg::CC_POL_BIT]; // R9
                        end
                    end
                    cpt_pkg::OFS_IRQ_MASK:
                    begin
                        if (wbSel[0])
                        begin
                            next_r.irqMask = wbWrData[1:0];
                        end
                    end
                    default: next_r.ack = 1'b1;
                endcase
            end
        end
    end

    // ==============================================================
    // registers; everything clears, which leaves the timer without a clock
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r <= '0; // R2
        end
        else
        begin
            r <= next_r;
        end
    end

    // ==============================================================
    // outputs
    assign wbRdData = r.dat;
    assign wbAck = r.ack;
    assign pwmOut = r.pwm;
    assign irq = (|(r.irqStat & r.irqMask)) | (r.ovf & r.ovfIe);

endmodule

`default_nettype wire

// File: cpt_timer_chk.sv
// checker for the pwm timer: bus handshake, read data and interrupt relations
// assumes it is bound to cpt_timer and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module cpt_timer_chk
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbWrData,
    input wire logic [31:0] wbRdData,
    input wire logic wbAck,
    input wire logic extClkPin,
    input wire logic fixedClkPin,
    input wire logic pwmOut,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    typedef struct packed {logic ovfIe; logic [1:0] mask;} cpt_shadow_s;
    cpt_shadow_s shadow;
    cpt_shadow_s next_shadow;
    logic wrLow;
    // ==============================================================
    // shadow of the interrupt enables, taken on the same edge as the design
    assign wrLow = wbCyc && wbStb && !wbAck && wbWe && wbSel[0];
    always_comb
    begin
        next_shadow = shadow;
        if (wrLow && wbAdr == cpt_pkg::OFS_STATUS_CONTROL)
            next_shadow.ovfIe = wbWrData[cpt_pkg::SC_OVF_IE_BIT];
        if (wrLow && wbAdr == cpt_pkg::OFS_IRQ_MASK)
            next_shadow.mask = wbWrData[1:0];
    end
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            shadow <= '0;
        else
            shadow <= next_shadow;
    end
    // ==============================================================
    // properties
    sequence s_take; wbCyc && wbStb && !wbAck; endsequence
    sequence s_status_read; wbAck && !$past(wbWe) && $past(wbAdr) == cpt_pkg::OFS_STATUS_CONTROL; endsequence
    property p_ack_after_take; s_take |=> wbAck; endproperty
    property p_ack_pulse; wbAck |=> !wbAck; endproperty
    property p_ack_cause; wbAck |-> $past(wbCyc && wbStb); endproperty
    property p_upper_zero; wbRdData[31:16] == 16'h0000; endproperty
    property p_write_zero; wbAck && $past(wbWe) |-> wbRdData == 32'h0000_0000; endproperty
    property p_rd_hold; !wbAck |-> $stable(wbRdData); endproperty
    property p_ovf_irq; s_status_read ##0 (wbRdData[7] && wbRdData[6]) |-> irq; endproperty
    property p_irq_masked; !shadow.ovfIe && shadow.mask == 2'h0 |-> !irq; endproperty
    a_ack_after_take: assert property (p_ack_after_take) else $error("no ack after request");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_upper_zero: assert property (p_upper_zero) else $error("upper read data not zero");
    a_write_zero: assert property (p_write_zero) else $error("read data not zero after write");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved between accesses");
    a_ovf_irq: assert property (p_ovf_irq) else $error("enabled overflow without irq");
    a_irq_masked: assert property (p_irq_masked) else $error("irq while all sources masked");
endmodule
bind cpt_timer cpt_timer_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbWrData(wbWrData), .wbRdData(wbRdData), .wbAck(wbAck),
    .extClkPin(extClkPin), .fixedClkPin(fixedClkPin), .pwmOut(pwmOut), .irq(irq));
`default_nettype wire

// File: cpt_pwm_load.sv
// load on the pwm pin: length of each completed high and low run
// assumes the pin is sampled on the bus clock
`timescale 1ns/100ps
`default_nettype none
module cpt_pwm_load
(
    input wire logic ref_clk,
    input wire logic pwmIn,
    output logic [15:0] highLen,
    output logic [15:0] lowLen
);
    logic [15:0] run = 16'h0001;
    logic last = 1'b0;
    // ==============================================================
    // run-length capture; a motor drive only sees the pin level
    always @(posedge ref_clk)
    begin
        last <= pwmIn;
        run <= (pwmIn === last) ? run + 16'h0001 : 16'h0001;
        if (pwmIn !== last && last)
            highLen <= run;
        if (pwmIn !== last && !last)
            lowLen <= run;
    end
endmodule
`default_nettype wire

// File: cpt_timer_bench.sv
// testbench for the pwm timer: wishbone tasks, pwm shape and interrupt tests
// assumes the checker is bound to the design and the load model sits on the pin
`timescale 1ns/100ps
`default_nettype none
module cpt_timer_bench;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbWrData = 32'h0000_0000;
    logic [31:0] wbRdData;
    logic wbAck;
    logic extClkPin = 1'b0;
    logic fixedClkPin = 1'b0;
    logic pwmOut;
    logic irq;
    logic [15:0] highLen;
    logic [15:0] lowLen;
    logic [31:0] q;
    logic [31:0] qs;
    logic [15:0] chv [3] = '{16'h0000, 16'h8001, 16'h0005};
    int onesExp [3] = '{0, 0, 20};
    int perv [3] = '{1, 8, 10};
    int psv [3] = '{0, 1, 0};
    int hExp [3] = '{2, 4, 6};
    int lExp [3] = '{6, 12, 2};
    int miscompares = 0;
    int numChecks = 0;
    int ph = 0;
    int ones;
    cpt_timer dut (.ref_clk(ref_clk), .reset_n(reset_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbWrData(wbWrData), .wbRdData(wbRdData), .wbAck(wbAck),
        .extClkPin(extClkPin), .fixedClkPin(fixedClkPin), .pwmOut(pwmOut), .irq(irq));
    cpt_pwm_load load (.ref_clk(ref_clk), .pwmIn(pwmOut), .highLen(highLen), .lowLen(lowLen));
    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end
    // ==============================================================
    // clock pins run free: fixed period 8 cycles, external period 10
    always @(posedge ref_clk)
    begin
        ph <= ph + 1;
        fixedClkPin <= ph[2];
        extClkPin <= (ph % 10) < 5;
    end
    // ==============================================================
    // tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // no cycle count is assumed for the answer; a wait ends on the ack or at the bound of 20 cycles
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge ref_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbWrData <= d;
        wbSel <= s;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (wbAck !== 1'b1 && n < 20);
        q = wbRdData;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        if (wbAck !== 1'b1)
        begin
            miscompares++;
            close_out();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'h3);
    endtask
    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 32'h0, 4'h3);
    endtask
    // ==============================================================
    // main sequence
    initial
    begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(8'h00);
        check("statusReset", q, 32'h0);
        rd(8'h04);
        check("counterReset", q, 32'h0);
        rd(8'h1c);
        check("unmapped", q, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h04, 32'h0);
            wr(8'h00, (i + 1) << 3);
            repeat (200) @(posedge ref_clk);
            wr(8'h00, 32'h0);
            rd(8'h04);
            check("runCount", (q >= 200 / perv[i] - 2) && (q <= 200 / perv[i] + 8), 32'h1);
            qs = q;
            rd(8'h04);
            check("heldCount", q, qs);
        end
        $display("test clock sources done");
        wr(8'h08, 32'h4);
        wr(8'h10, 32'h0);
        for (int k = 0; k < 3; k++)
        begin
            wr(8'h00, 32'h0);
            wr(8'h0c, chv[k]);
            wr(8'h04, 32'h0);
            wr(8'h00, 32'h28);
            repeat (10) @(posedge ref_clk);
            ones = 0;
            repeat (20) @(posedge ref_clk) ones += (pwmOut === 1'b1);
            check("constLevel", ones, onesExp[k]);
        end
        $display("test constant duty done");
        wr(8'h0c, 32'h1);
        for (int k = 0; k < 3; k++)
        begin
            wr(8'h10, k / 2);
            wr(8'h04, 32'h0);
            wr(8'h00, 32'h28 | psv[k]);
            repeat (60) @(posedge ref_clk);
            check("highLen", highLen, hExp[k]);
            check("lowLen", lowLen, lExp[k]);
        end
        $display("test pulse shape done");
        wr(8'h18, 32'h1);
        repeat (20) @(posedge ref_clk);
        check("irqRaised", irq, 32'h1);
        wr(8'h18, 32'h0);
        check("irqMasked", irq, 32'h0);
        wr(8'h00, 32'h60);
        check("irqOvf", irq, 32'h1);
        rd(8'h00);
        check("statusFlag", q, 32'he0);
        wb(1'b1, 8'h00, 32'h60, 4'h1);
        rd(8'h00);
        check("flagCleared", q, 32'h60);
        check("irqQuiet", irq, 32'h0);
        wr(8'h18, 32'h1);
        check("irqPending", irq, 32'h1);
        wr(8'h18, 32'h2);
        check("irqMatch", irq, 32'h1);
        rd(8'h14);
        check("eventSeen", q[0], 32'h1);
        check("matchSeen", q[1], 32'h1);
        check("irqCleared", irq, 32'h0);
        rd(8'h08);
        check("moduloKept", q, 32'h4);
        $display("test interrupts done");
        // ==============================================================
        // free-running wrap; the buffered modulo waits for the step to the top count
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h0);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h3);
        wr(8'h00, 32'h08);
        repeat (65520) @(posedge ref_clk);
        rd(8'h04);
        check("freeRun", q > 32'hff00, 32'h1);
        rd(8'h08);
        check("moduloBuffered", q, 32'h0);
        repeat (20) @(posedge ref_clk);
        rd(8'h08);
        check("moduloLoaded", q, 32'h3);
        rd(8'h04);
        check("wrapCount", q <= 32'h3, 32'h1);
        rd(8'h00);
        check("wrapFlag", q, 32'h88);
        $display("test free run done");
        close_out();
    end
endmodule
`default_nettype wire
